/* src/dramel_pkg.sv */
// Constants and types for the DRAM error logging block
package dramel_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] STATUS_LO_OFFSET   = 12'h280;
	localparam logic [11:0] STATUS_HI_OFFSET   = 12'h284;
	localparam logic [11:0] CONTROL_OFFSET     = 12'h300;
	localparam logic [11:0] EVENT_OFFSET       = 12'h304;

	// Status register fields, 64-bit view
	localparam int MEU_BIT   = 63;
	localparam int MEC_BIT   = 62;
	localparam int DAC_BIT   = 61;
	localparam int DAU_BIT   = 60;
	localparam int DSC_BIT   = 59;
	localparam int DSU_BIT   = 58;
	localparam int OOB_BIT   = 57;
	localparam int SYND_W    = 16;

	// Control register fields
	localparam int CTL_L2_UE_EN   = 0;
	localparam int CTL_CORE_UE_EN = 1;
	localparam int CTL_MA_NOTIFY  = 2;
	localparam int CTL_STEER_LSB  = 8;
	localparam int STRAND_W       = 5;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

	// Fixed geometry
	localparam int CHUNKS_PER_LINE = 16;
	localparam int BLOCKS_PER_LINE = 4;
	localparam logic [6:0] POISON_CHECK = 7'h7F;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Kinds of request that a reply answers
	typedef enum logic [3:0]
	{
		DRAMEL_LOAD     = 4'h0,
		DRAMEL_FETCH    = 4'h1,
		DRAMEL_ATOMIC   = 4'h2,
		DRAMEL_PREFETCH = 4'h3,
		DRAMEL_STORE    = 4'h4,
		DRAMEL_PSTORE   = 4'h5,
		DRAMEL_MA_STORE = 4'h6,
		DRAMEL_MA_LOAD  = 4'h7,
		DRAMEL_DMA_RD   = 4'h8,
		DRAMEL_DMA_WRP  = 4'h9
	} dramel_kind_t;

	// L2 status code reported for a reply
	typedef enum logic [1:0]
	{
		DRAMEL_L2_NONE = 2'h0,
		DRAMEL_L2_ACC  = 2'h1,
		DRAMEL_L2_DMA  = 2'h2,
		DRAMEL_L2_LDAU = 2'h3
	} dramel_l2code_t;

	// Slave write state
	typedef enum logic [1:0]
	{
		DRAMEL_W_IDLE = 2'h0,
		DRAMEL_W_RESP = 2'h1
	} dramel_wstate_t;

endpackage : dramel_pkg

/* src/dramel_top.sv */
// DRAM error logging: reply handling, status register and AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// What this block does
// - Out-of-bounds reply poisons every line portion
// - L2 fill writes poisoned check bits per chunk
// - Always log L2; core log when enabled, except for store kinds
// - Atomic on faulting word: keep data, mark dirty
// - Replay before fill gives precise fault, L1 parity
// - Fill first: disrupting fault, then L2 multi flag
// - CPU accesses: L2 access-uncorrectable, memory out-of-bounds
// - DMA accesses: L2 DMA code, memory out-of-bounds
// - Store-type misses trap only with both enables
// - Partial store keeps data, marks line dirty
// - MA load forwards error, unit aborts if L2 UE enable set, logs
// - Core enable and notify select MA outcome
// - DMA read returns data with error flag
// - DMA partial write to bad block suppressed, dirty
// - Flags clear by writing one; reset keeps
// - Status bit layout, syndrome low sixteen bits
// - Same-cycle CE and UE: mec plus UE flag
// - UE priority one; syndrome captured
// - Several bad blocks in one access: multiple
// - Existing flag decides multi or overwrite
// - Hardware never clears a set flag
// - Coincident write: error fields win, others write
module dramel_top
(
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_reset,
	// AXI4-Lite slave
	input  wire logic [11:0]               i_awaddr,
	input  wire logic                      i_awvalid,
	output logic                           o_awready,
	input  wire logic [31:0]               i_wdata,
	input  wire logic [3:0]                i_wstrb,
	input  wire logic                      i_wvalid,
	output logic                           o_wready,
	output logic [1:0]                     o_bresp,
	output logic                           o_bvalid,
	input  wire logic                      i_bready,
	input  wire logic [11:0]               i_araddr,
	input  wire logic                      i_arvalid,
	output logic                           o_arready,
	output logic [31:0]                    o_rdata,
	output logic [1:0]                     o_rresp,
	output logic                           o_rvalid,
	input  wire logic                      i_rready,
	// DRAM reply from memory controller
	input  wire logic                      i_reply_valid,
	input  wire logic [3:0]                i_reply_kind,
	input  wire logic                      i_reply_oob,
	input  wire logic [3:0]                i_reply_ue_blocks,
	input  wire logic                      i_reply_ce,
	input  wire logic                      i_reply_scrub,
	input  wire logic [15:0]               i_reply_synd,
	input  wire logic                      i_reply_word_hit,
	input  wire logic                      i_replay_first,
	// Core-side enables
	input  wire logic                      i_core_ue_en,
	input  wire logic [4:0]                i_ma_strand,
	// Results
	output logic [15:0]                    o_fill_poison,
	output logic [6:0]                     o_fill_check,
	output logic                           o_fill_suppress,
	output logic                           o_line_dirty,
	output logic [1:0]                     o_l2_code,
	output logic                           o_l2_log,
	output logic                           o_core_log,
	output logic                           o_precise_load_fault,
	output logic                           o_precise_fetch_fault,
	output logic                           o_l1_bad_parity,
	output logic                           o_disrupting_fault,
	output logic [4:0]                     o_fault_strand,
	output logic                           o_ma_abort,
	output logic                           o_ma_done_trap,
	output logic                           o_ma_reg_fault,
	output logic                           o_dma_rd_error,
	output logic                           o_l2_multi_uncorr,
	output logic [63:0]                    o_status
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [63:0]  status;
	logic [31:0]  control;
	logic [7:0]   event_count;
	dramel_pkg::dramel_wstate_t wstate;
	logic         aw_held;
	logic         w_held;
	logic [11:0]  aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;

	wire l2_en    = control[dramel_pkg::CTL_L2_UE_EN];
	wire ma_notif = control[dramel_pkg::CTL_MA_NOTIFY];
	wire [4:0] steer = control[dramel_pkg::CTL_STEER_LSB +: dramel_pkg::STRAND_W];

	// ----------------------------------------------------------------
	// Reply decode
	// ----------------------------------------------------------------
	function automatic logic is_kind(input logic [3:0] k, input dramel_pkg::dramel_kind_t t);
		is_kind = (k == 4'(t));
	endfunction : is_kind

	wire k_load   = is_kind(i_reply_kind, dramel_pkg::DRAMEL_LOAD);
	wire k_fetch  = is_kind(i_reply_kind, dramel_pkg::DRAMEL_FETCH);
	wire k_atomic = is_kind(i_reply_kind, dramel_pkg::DRAMEL_ATOMIC);
	wire k_pref   = is_kind(i_reply_kind, dramel_pkg::DRAMEL_PREFETCH);
	wire k_store  = is_kind(i_reply_kind, dramel_pkg::DRAMEL_STORE);
	wire k_pstore = is_kind(i_reply_kind, dramel_pkg::DRAMEL_PSTORE);
	wire k_mast   = is_kind(i_reply_kind, dramel_pkg::DRAMEL_MA_STORE);
	wire k_mald   = is_kind(i_reply_kind, dramel_pkg::DRAMEL_MA_LOAD);
	wire k_dmard  = is_kind(i_reply_kind, dramel_pkg::DRAMEL_DMA_RD);
	wire k_dmawp  = is_kind(i_reply_kind, dramel_pkg::DRAMEL_DMA_WRP);
	wire k_dma    = k_dmard | k_dmawp;
	wire both_en  = l2_en & i_core_ue_en;

	// Out-of-bounds marks every block bad
	wire [3:0] ue_blocks = i_reply_oob ? 4'hF : i_reply_ue_blocks;
	wire       any_ue    = i_reply_valid & (|ue_blocks);
	wire       ue_count2 = ($countones(ue_blocks) > 1);
	wire       oob_ev    = i_reply_valid & i_reply_oob;
	wire       ldf       = k_load | k_fetch | k_atomic;
	wire       st_kind   = k_pref | k_store | k_pstore | k_mast;
	wire       keep_data = any_ue & (k_atomic | k_pstore | k_dmawp) & (i_reply_oob | i_reply_word_hit);

	// ----------------------------------------------------------------
	// Status update
	// ----------------------------------------------------------------
	wire ev_ue   = any_ue & ~i_reply_oob;
	wire ev_dau  = ev_ue & ~i_reply_scrub;
	wire ev_dsu  = ev_ue & i_reply_scrub;
	wire ev_ce   = i_reply_valid & i_reply_ce & ~any_ue;
	wire ev_cex  = i_reply_valid & i_reply_ce;
	wire ue_old  = status[dramel_pkg::DAU_BIT] | status[dramel_pkg::DSU_BIT] | status[dramel_pkg::OOB_BIT];
	wire ce_old  = status[dramel_pkg::DAC_BIT] | status[dramel_pkg::DSC_BIT];
	wire ue_new  = ev_dau | ev_dsu | oob_ev;
	// Flags and syndrome decided from pre-write state
	wire set_meu  = ue_new & (ue_old | ue_count2);
	wire set_mec  = (ev_cex & (ue_new | ue_old | ce_old));
	wire own_ue   = ue_new & ~ue_old;
	wire own_ce   = ev_ce & ~ue_old & ~ce_old;
	wire take_syn = own_ue | own_ce;

	logic [63:0] sw_status;
	logic [63:0] next_status;
	wire sw_lo = w_held & aw_held & (aw_addr == dramel_pkg::STATUS_LO_OFFSET) & (wstate == dramel_pkg::DRAMEL_W_IDLE);
	wire sw_hi = w_held & aw_held & (aw_addr == dramel_pkg::STATUS_HI_OFFSET) & (wstate == dramel_pkg::DRAMEL_W_IDLE);

	always_comb
	begin
		sw_status = status;
		// Upper word: flags are write-one-to-clear
		if (sw_hi && w_strb[3])
			sw_status[63:57] = status[63:57] & ~w_data[31:25];
		if (sw_lo && w_strb[0])
			sw_status[7:0] = w_data[7:0];
		if (sw_lo && w_strb[1])
			sw_status[15:8] = w_data[15:8];
		sw_status[56:16] = '0;
		next_status = sw_status;
		// Error-set fields override the write; flags only set
		if (set_meu)
			next_status[dramel_pkg::MEU_BIT] = 1'b1;
		if (set_mec)
			next_status[dramel_pkg::MEC_BIT] = 1'b1;
		if (own_ue && ev_dau)
			next_status[dramel_pkg::DAU_BIT] = 1'b1;
		if (own_ue && ev_dsu)
			next_status[dramel_pkg::DSU_BIT] = 1'b1;
		if (own_ue && oob_ev)
			next_status[dramel_pkg::OOB_BIT] = 1'b1;
		if (own_ce && !i_reply_scrub)
			next_status[dramel_pkg::DAC_BIT] = 1'b1;
		if (own_ce && i_reply_scrub)
			next_status[dramel_pkg::DSC_BIT] = 1'b1;
		if (take_syn)
			next_status[15:0] = i_reply_synd;
	end

	// Not reset: contents survive reset
	always_ff @(posedge i_ref_clk)
	begin
		status <= next_status;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	wire wr_fire = aw_held & w_held & (wstate == dramel_pkg::DRAMEL_W_IDLE);
	wire wr_ok   = (aw_addr == dramel_pkg::STATUS_LO_OFFSET) | (aw_addr == dramel_pkg::STATUS_HI_OFFSET) |
	               (aw_addr == dramel_pkg::CONTROL_OFFSET);
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb
	begin
		rd_ok = 1'b1;
		case (i_araddr)
			dramel_pkg::STATUS_LO_OFFSET: rd_mux = status[31:0];
			dramel_pkg::STATUS_HI_OFFSET: rd_mux = status[63:32];
			dramel_pkg::CONTROL_OFFSET:   rd_mux = control;
			dramel_pkg::EVENT_OFFSET:     rd_mux = {24'h000000, event_count};
			default:
			begin
				rd_mux = 32'h0000_0000;
				rd_ok  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wstate    <= dramel_pkg::DRAMEL_W_IDLE;
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr   <= 12'h000;
			w_data    <= 32'h0000_0000;
			w_strb    <= 4'h0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= dramel_pkg::RESP_OKAY;
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= dramel_pkg::RESP_OKAY;
			control   <= dramel_pkg::CONTROL_RESET;
		end
		else
		begin
			o_awready <= ~aw_held & ~o_awready & i_awvalid;
			o_wready  <= ~w_held & ~o_wready & i_wvalid;
			if (i_awvalid && o_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= {i_awaddr[11:2], 2'b00};
			end
			if (i_wvalid && o_wready)
			begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			case (wstate)
				dramel_pkg::DRAMEL_W_IDLE:
					if (wr_fire)
					begin
						if (aw_addr == dramel_pkg::CONTROL_OFFSET && w_strb[0])
							control[7:0] <= w_data[7:0];
						if (aw_addr == dramel_pkg::CONTROL_OFFSET && w_strb[1])
							control[15:8] <= w_data[15:8];
						o_bvalid <= 1'b1;
						o_bresp  <= wr_ok ? dramel_pkg::RESP_OKAY : dramel_pkg::RESP_SLVERR;
						wstate   <= dramel_pkg::DRAMEL_W_RESP;
					end
				dramel_pkg::DRAMEL_W_RESP:
					if (i_bready)
					begin
						o_bvalid <= 1'b0;
						aw_held  <= 1'b0;
						w_held   <= 1'b0;
						wstate   <= dramel_pkg::DRAMEL_W_IDLE;
					end
				default:
					wstate <= dramel_pkg::DRAMEL_W_IDLE;
			endcase
			o_arready <= ~o_arready & ~o_rvalid & i_arvalid;
			if (i_arvalid && o_arready)
			begin
				o_rvalid <= 1'b1;
				o_rdata  <= rd_mux;
				o_rresp  <= rd_ok ? dramel_pkg::RESP_OKAY : dramel_pkg::RESP_SLVERR;
			end
			else if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Reply outcome
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_fill_poison         <= 16'h0000;
			o_fill_check          <= 7'h00;
			o_fill_suppress       <= 1'b0;
			o_line_dirty          <= 1'b0;
			o_l2_code             <= 2'h0;
			o_l2_log              <= 1'b0;
			o_core_log            <= 1'b0;
			o_precise_load_fault  <= 1'b0;
			o_precise_fetch_fault <= 1'b0;
			o_l1_bad_parity       <= 1'b0;
			o_disrupting_fault    <= 1'b0;
			o_fault_strand        <= 5'h00;
			o_ma_abort            <= 1'b0;
			o_ma_done_trap        <= 1'b0;
			o_ma_reg_fault        <= 1'b0;
			o_dma_rd_error        <= 1'b0;
			o_l2_multi_uncorr     <= 1'b0;
			event_count           <= 8'h00;
			o_status              <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			o_status <= status;
			// Each 32-bit chunk of a bad block gets poisoned check bits
			o_fill_poison <= any_ue ? {{4{ue_blocks[3]}}, {4{ue_blocks[2]}}, {4{ue_blocks[1]}},
			                           {4{ue_blocks[0]}}} : 16'h0000;
			o_fill_check  <= any_ue ? dramel_pkg::POISON_CHECK : 7'h00;
			o_fill_suppress <= keep_data;
			o_line_dirty    <= keep_data;
			o_l2_log   <= oob_ev;
			o_core_log <= oob_ev & l2_en & ~st_kind;
			if (oob_ev)
				o_l2_code <= k_dma ? 2'(dramel_pkg::DRAMEL_L2_DMA) : 2'(dramel_pkg::DRAMEL_L2_ACC);
			else if (!i_reply_valid)
				o_l2_code <= 2'(dramel_pkg::DRAMEL_L2_NONE);
			// Replay before fill: precise fault and L1 parity
			o_precise_load_fault  <= oob_ev & both_en & i_replay_first & (k_load | k_atomic);
			o_precise_fetch_fault <= oob_ev & both_en & i_replay_first & k_fetch;
			o_l1_bad_parity       <= oob_ev & both_en & i_replay_first & ldf;
			// Fill first: disrupting fault then second uncorrectable log
			o_l2_multi_uncorr <= oob_ev & both_en & ~i_replay_first & ldf;
			o_dma_rd_error    <= oob_ev & k_dmard;
			o_ma_abort        <= oob_ev & k_mald & l2_en;
			// Outcome after the abort
			o_ma_done_trap <= o_ma_abort & ~i_core_ue_en & ma_notif;
			o_ma_reg_fault <= o_ma_abort & i_core_ue_en & ~ma_notif;
			if (o_ma_abort && i_core_ue_en && ma_notif)
			begin
				o_disrupting_fault <= 1'b1;
				o_fault_strand     <= i_ma_strand;
			end
			else if (oob_ev && both_en && ((ldf && !i_replay_first) || st_kind || k_dma))
			begin
				o_disrupting_fault <= 1'b1;
				o_fault_strand     <= steer;
			end
			else
				o_disrupting_fault <= 1'b0;
			if (oob_ev && event_count != 8'hFF)
				event_count <= event_count + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_OOB_POISON: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		oob_ev |=> (o_fill_poison == 16'hFFFF))
		else $error("Out-of-bounds reply not fully poisoned");
	AST_L2_LOG: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		oob_ev |=> o_l2_log)
		else $error("Out-of-bounds reply not logged in L2");
	AST_KEEP_DIRTY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(oob_ev && k_pstore) |=> (o_fill_suppress && o_line_dirty))
		else $error("Partial store not suppressed with dirty line");
	AST_PRECISE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(oob_ev && both_en && i_replay_first && k_fetch) |=> (o_precise_fetch_fault && !o_precise_load_fault))
		else $error("Wrong precise fault for fetch");
	AST_STORE_TRAP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(oob_ev && st_kind && !both_en && !o_ma_abort) |=> !o_disrupting_fault)
		else $error("Store trap without both enables");
	AST_MA_BOTH: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(o_ma_abort && i_core_ue_en && ma_notif) |=> (o_disrupting_fault && !o_ma_done_trap))
		else $error("MA abort outcome wrong");
	AST_NO_HW_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		($past(status[dramel_pkg::DAU_BIT]) && !$past(sw_hi)) |-> status[dramel_pkg::DAU_BIT])
		else $error("Hardware cleared a status flag");
	AST_MEC_SAME: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(ev_dau && ev_cex) |=> (status[dramel_pkg::MEC_BIT] && !status[dramel_pkg::DAC_BIT] ||
		$past(status[dramel_pkg::DAC_BIT])))
		else $error("Same-cycle errors not flagged as multiple");
	AST_DMA_ERR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(oob_ev && k_dmard) |=> o_dma_rd_error)
		else $error("DMA read error indicator missing");

endmodule : dramel_top

/* verif/dramel_reply_model.sv */
// Far-side model: memory controller and L2 reply path feeding the block
`timescale 1ns/1ps

module dramel_reply_model
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	input  wire logic        i_go,
	input  wire logic [28:0] i_fields,
	output logic             o_reply_valid,
	output logic [3:0]       o_reply_kind,
	output logic             o_reply_oob,
	output logic [3:0]       o_reply_ue_blocks,
	output logic             o_reply_ce,
	output logic             o_reply_scrub,
	output logic [15:0]      o_reply_synd,
	output logic             o_reply_word_hit,
	output logic             o_replay_first
);
	logic [28:0] fields;

	// ------------------------------------------------------------
	// Reply launch, one cycle per request
	// ------------------------------------------------------------
	// Idle fields flip each cycle so stale values never pass for a reply
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_reply_valid <= 1'h0;
			fields        <= 29'h0;
		end
		else
		begin
			o_reply_valid <= i_go;
			fields        <= i_go ? i_fields : ~fields;
		end
	end

	assign {o_reply_kind, o_reply_oob, o_reply_ue_blocks, o_reply_ce, o_reply_scrub, o_reply_synd,
		o_reply_word_hit, o_replay_first} = fields;
endmodule : dramel_reply_model

/* verif/dramel_top_tb.sv */
// Self-checking bench for the DRAM error logging block
`timescale 1ns/1ps

module dramel_top_tb;
	localparam logic [4:0] STEER     = 5'h13;
	localparam logic [4:0] MA_STRAND = 5'h0A;
	localparam int         LIMIT     = 5000;

	typedef struct packed
	{
		logic [3:0]  kind;
		logic        hit;
		logic        rf;
		logic        l2en;
		logic        core;
		logic [10:0] exp;
		logic [10:0] msk;
	} dramel_row_t;

	logic        i_ref_clk;
	logic        i_reset;
	logic [11:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0]  i_wstrb, i_reply_kind, i_reply_ue_blocks;
	logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_core_ue_en;
	logic [4:0]  i_ma_strand, o_fault_strand;
	logic        i_reply_valid, i_reply_oob, i_reply_ce, i_reply_scrub, i_reply_word_hit, i_replay_first;
	logic [15:0] i_reply_synd, o_fill_poison;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_fill_suppress, o_line_dirty;
	logic [1:0]  o_bresp, o_rresp, o_l2_code, r;
	logic [6:0]  o_fill_check;
	logic        o_l2_log, o_core_log, o_precise_load_fault, o_precise_fetch_fault, o_l1_bad_parity;
	logic        o_disrupting_fault, o_ma_abort, o_ma_done_trap, o_ma_reg_fault, o_dma_rd_error, o_l2_multi_uncorr;
	logic [63:0] o_status;
	logic        go;
	logic [28:0] fields;
	int          errors, checked, cycles;

	// Outputs: code, l2 log, core log, load/fetch fault, parity, disrupt, suppress, dirty, dma error
	dramel_row_t rows [13] = '{
		'{4'h0, 1'h0, 1'h1, 1'h1, 1'h1, 11'h3D0, 11'h7FD}, '{4'h1, 1'h0, 1'h1, 1'h1, 1'h1, 11'h3B0, 11'h7FD},
		'{4'h0, 1'h0, 1'h0, 1'h1, 1'h1, 11'h388, 11'h7ED}, '{4'h0, 1'h0, 1'h1, 1'h1, 1'h0, 11'h380, 11'h7ED},
		'{4'h0, 1'h0, 1'h1, 1'h0, 1'h1, 11'h300, 11'h7ED}, '{4'h2, 1'h1, 1'h1, 1'h1, 1'h1, 11'h3D6, 11'h7FF},
		'{4'h4, 1'h0, 1'h0, 1'h1, 1'h1, 11'h308, 11'h7ED}, '{4'h4, 1'h0, 1'h0, 1'h1, 1'h0, 11'h300, 11'h7ED},
		'{4'h3, 1'h0, 1'h0, 1'h1, 1'h1, 11'h308, 11'h7ED}, '{4'h5, 1'h1, 1'h0, 1'h1, 1'h1, 11'h30E, 11'h7EF},
		'{4'h6, 1'h0, 1'h0, 1'h0, 1'h1, 11'h300, 11'h7ED}, '{4'h8, 1'h0, 1'h0, 1'h1, 1'h1, 11'h589, 11'h7ED},
		'{4'h9, 1'h1, 1'h0, 1'h1, 1'h1, 11'h58E, 11'h7EF}};
	logic [2:0] ma_exp [5] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h0};

	dramel_top i_dramel_top (.*);

	dramel_reply_model i_dramel_reply_model
	(
		.i_ref_clk         (i_ref_clk),
		.i_reset           (i_reset),
		.i_go              (go),
		.i_fields          (fields),
		.o_reply_valid     (i_reply_valid),
		.o_reply_kind      (i_reply_kind),
		.o_reply_oob       (i_reply_oob),
		.o_reply_ue_blocks (i_reply_ue_blocks),
		.o_reply_ce        (i_reply_ce),
		.o_reply_scrub     (i_reply_scrub),
		.o_reply_synd      (i_reply_synd),
		.o_reply_word_hit  (i_reply_word_hit),
		.o_replay_first    (i_replay_first)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic got_a;
		logic got_w;
		got_a = 1'h0;
		got_w = 1'h0;
		@(posedge i_ref_clk);
		i_awaddr  <= a;
		i_wdata   <= d;
		i_awvalid <= 1'h1;
		i_wvalid  <= 1'h1;
		i_bready  <= 1'h1;
		while (!(got_a && got_w))
		begin
			@(posedge i_ref_clk);
			got_a = got_a || o_awready === 1'h1;
			got_w = got_w || o_wready === 1'h1;
			i_awvalid <= !got_a;
			i_wvalid  <= !got_w;
		end
		while (o_bvalid !== 1'h1)
			@(posedge i_ref_clk);
		rs = o_bresp;
		i_bready <= 1'h0;
	endtask : axi_wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge i_ref_clk);
		i_araddr  <= a;
		i_arvalid <= 1'h1;
		i_rready  <= 1'h1;
		do
			@(posedge i_ref_clk);
		while (o_arready !== 1'h1);
		i_arvalid <= 1'h0;
		while (o_rvalid !== 1'h1)
			@(posedge i_ref_clk);
		chk({o_rresp, o_rdata}, {er, e});
		i_rready <= 1'h0;
	endtask : rd_chk

	task automatic send(input logic [28:0] f);
		@(posedge i_ref_clk);
		fields <= f;
		go     <= 1'h1;
		@(posedge i_ref_clk);
		go <= 1'h0;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask : send

	task automatic ctl(input logic l2en, input logic notify);
		axi_wr(dramel_pkg::CONTROL_OFFSET, {19'h0, STEER, 5'h0, notify, 1'h0, l2en}, r);
	endtask : ctl

	task automatic clr();
		axi_wr(dramel_pkg::STATUS_HI_OFFSET, 32'hFE00_0000, r);
	endtask : clr

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial
	begin
		i_ref_clk = 1'h0;
		forever
			#12.5 i_ref_clk = ~i_ref_clk;
	end

	always @(posedge i_ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			errors++;
			complete_run();
		end
	end

	initial
	begin
		{errors, checked} = 64'h0;
		i_reset = 1'h1;
		i_wstrb = 4'hF;
		i_ma_strand = MA_STRAND;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_core_ue_en, go} = 7'h0;
		{i_awaddr, i_araddr, i_wdata, fields} = 85'h0;
		repeat (16) @(posedge i_ref_clk);
		chk({o_bvalid, o_rvalid, o_awready, o_disrupting_fault, o_fill_poison}, 64'h0);
		i_reset <= 1'h0;
		clr();
		axi_wr(dramel_pkg::STATUS_LO_OFFSET, 32'hFFFF_FFFF, r);
		rd_chk(dramel_pkg::STATUS_LO_OFFSET, 32'h0000_FFFF, dramel_pkg::RESP_OKAY);
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h0, dramel_pkg::RESP_OKAY);
		axi_wr(12'h3F0, 32'hFFFF_FFFF, r);
		chk(r, dramel_pkg::RESP_SLVERR);
		rd_chk(12'h3F0, 32'h0, dramel_pkg::RESP_SLVERR);
		for (int i = 0; i < 13; i++)
		begin
			i_core_ue_en <= rows[i].core;
			ctl(rows[i].l2en, 1'h0);
			send({rows[i].kind, 1'h1, 4'h0, 2'h0, 16'h0, rows[i].hit, rows[i].rf});
			chk({o_l2_code, o_l2_log, o_core_log, o_precise_load_fault, o_precise_fetch_fault, o_l1_bad_parity,
				o_disrupting_fault, o_fill_suppress, o_line_dirty, o_dma_rd_error} & rows[i].msk,
				rows[i].exp & rows[i].msk);
			if (rows[i].kind != 4'h8)
				chk({o_fill_poison, o_fill_check}, {16'hFFFF, 7'h7F});
			if (rows[i].exp[3])
				chk(o_fault_strand, STEER);
			chk(o_l2_multi_uncorr, rows[i].exp[3] && rows[i].kind < 4'h3);
		end
		for (int c = 0; c < 5; c++)
		begin
			i_core_ue_en <= c[1];
			ctl(c < 4, c[0]);
			send({dramel_pkg::DRAMEL_MA_LOAD, 1'h1, 4'h0, 2'h0, 16'h0, 2'h0});
			chk(o_ma_abort, c < 4);
			@(negedge i_ref_clk);
			chk({o_disrupting_fault, o_ma_done_trap, o_ma_reg_fault}, ma_exp[c]);
			if (c == 3)
				chk(o_fault_strand, MA_STRAND);
		end
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h8200_0000, dramel_pkg::RESP_OKAY);
		rd_chk(dramel_pkg::EVENT_OFFSET, 32'h0000_0012, dramel_pkg::RESP_OKAY);
		@(posedge i_ref_clk);
		i_reset <= 1'h1;
		repeat (16) @(posedge i_ref_clk);
		i_reset <= 1'h0;
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h8200_0000, dramel_pkg::RESP_OKAY);
		axi_wr(dramel_pkg::STATUS_HI_OFFSET, 32'h8000_0000, r);
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h0200_0000, dramel_pkg::RESP_OKAY);
		clr();
		axi_wr(dramel_pkg::STATUS_LO_OFFSET, 32'h0, r);
		send({4'h0, 1'h0, 4'h1, 2'h2, 16'hA5C3, 2'h0});
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h5000_0000, dramel_pkg::RESP_OKAY);
		send(29'h0);
		send({4'h0, 1'h0, 4'h0, 2'h2, 16'h1234, 2'h0});
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h5000_0000, dramel_pkg::RESP_OKAY);
		rd_chk(dramel_pkg::STATUS_LO_OFFSET, 32'h0000_A5C3, dramel_pkg::RESP_OKAY);
		clr();
		send({4'h0, 1'h0, 4'h5, 2'h0, 16'h0, 2'h0});
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h9000_0000, dramel_pkg::RESP_OKAY);
		clr();
		send({4'h0, 1'h0, 4'h0, 2'h2, 16'h1111, 2'h0});
		send({4'h0, 1'h0, 4'h1, 2'h1, 16'h2222, 2'h0});
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h2400_0000, dramel_pkg::RESP_OKAY);
		rd_chk(dramel_pkg::STATUS_LO_OFFSET, 32'h0000_2222, dramel_pkg::RESP_OKAY);
		chk(o_status, 64'h2400_0000_0000_2222);
		clr();
		send({4'h0, 1'h0, 4'h0, 2'h2, 16'h1111, 2'h0});
		// Clear of an access CE lands with a scrub UE
		fork
			axi_wr(dramel_pkg::STATUS_HI_OFFSET, 32'h2000_0000, r);
			begin
				@(posedge i_ref_clk);
				send({4'h0, 1'h0, 4'h1, 2'h1, 16'h3333, 2'h0});
			end
		join
		rd_chk(dramel_pkg::STATUS_HI_OFFSET, 32'h0400_0000, dramel_pkg::RESP_OKAY);
		rd_chk(dramel_pkg::STATUS_LO_OFFSET, 32'h0000_3333, dramel_pkg::RESP_OKAY);
		complete_run();
	end
endmodule : dramel_top_tb
